// ---- logic/pinsel_pkg.sv ----
// Constants, register map and carrier types for the port-2 pin function select block
// How it works
// - Four 8-bit read/write pin select registers, all zero after reset.
// - Bit 0 of each register enables the plain GPIO function of the pin.
// - Pin-1 bit 6 joins the I2C master data line; software sets open-drain.
// - Pin-1 bit 5 joins I2C slave one data line; software sets open-drain.
// - Pin-1 bit 4 routes capture/compare channel five I/O to the pin.
// - Pin-1 bit 2 drives the pin from UART two transmit.
// - Pin-1 bit 1 drives the pin from PWM unit one output.
// - Pin-5 bit 7 drives LED segment twenty-one onto the pin.
// - Pin-5 bit 4 routes capture/compare channel four I/O to the pin.
// - Pin-5 bit 3 joins the I2C master clock line; software sets open-drain.
// - Pin-5 bit 2 joins I2C slave one clock line; software sets open-drain.
// - Pin-5 bit 6 joins I2C slave two clock line; software sets open-drain.
package pinsel_pkg;

    localparam int ADDR_W = 18;
    localparam int DATA_W = 32;
    localparam int CFG_W  = 8;
    localparam int NPINS  = 4;

    // Register indices; byte address is four times the index
    localparam logic [15:0] PIN1_IDX = 16'hA071;
    localparam logic [15:0] PIN3_IDX = 16'hA073;
    localparam logic [15:0] PIN4_IDX = 16'hA074;
    localparam logic [15:0] PIN5_IDX = 16'hA075;

    localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

    // Writable bits; reserved bits hold zero
    localparam logic [CFG_W-1:0] PIN1_MASK = 8'hFF;
    localparam logic [CFG_W-1:0] PIN3_MASK = 8'hFF;
    localparam logic [CFG_W-1:0] PIN4_MASK = 8'hDD;
    localparam logic [CFG_W-1:0] PIN5_MASK = 8'hFD;

    // Slot numbers of the pins in the register array
    localparam int SLOT_P1 = 0;
    localparam int SLOT_P3 = 1;
    localparam int SLOT_P4 = 2;
    localparam int SLOT_P5 = 3;

    // Field positions
    localparam int GENERAL_IO_SEL          = 0;
    localparam int ANALOG_INPUT_ONE_SEL    = 7;
    localparam int P1_I2C_MASTER_DATA_SEL  = 6;
    localparam int P1_I2C_SLAVE_ONE_DATA   = 5;
    localparam int CAPCOMP_FIVE_IO_SEL     = 4;
    localparam int SPI_SLAVE_OUT_SEL       = 3;
    localparam int UART_TWO_TX_SEL         = 2;
    localparam int PWM_UNIT_ONE_OUT_SEL    = 1;
    localparam int LED_SEG_TWENTYTHREE_SEL = 7;
    localparam int UART_THREE_TX_SEL       = 6;
    localparam int UART_THREE_RX_SEL       = 5;
    localparam int UART_TWO_RX_SEL         = 4;
    localparam int SPI_SELECT_IN_SEL       = 3;
    localparam int UART_FOUR_TX_SEL        = 2;
    localparam int UART_FOUR_RX_SEL        = 1;
    localparam int LED_SEG_TWENTYTWO_SEL   = 7;
    localparam int I2C_SLAVE_TWO_DATA_SEL  = 6;
    localparam int TIMER_TWO_INPUT_SEL     = 4;
    localparam int P4_I2C_MASTER_DATA_SEL  = 3;
    localparam int P4_I2C_SLAVE_ONE_DATA   = 2;
    localparam int LED_SEG_TWENTYONE_SEL   = 7;
    localparam int I2C_SLAVE_TWO_CLOCK_SEL = 6;
    localparam int CAPCOMP_FOUR_IO_SEL     = 4;
    localparam int I2C_MASTER_CLOCK_SEL    = 3;
    localparam int I2C_SLAVE_ONE_CLOCK_SEL = 2;

    // One source driving a pad
    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

    // APB request lines
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              write;
        logic [DATA_W-1:0] wdata;
        logic [3:0]        strb;
    } apb_req_t;

    function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
        reg_addr = ADDR_W'({idx, 2'b00});
    endfunction

endpackage

// ---- logic/pin_route.sv ----
// Output selector for one pad: highest set select bit owns the pad
`timescale 1ns/1ps
`default_nettype none
module pin_route #(
    parameter int N = 8
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    input  wire logic [N-1:0]           i_sel,
    input  wire pinsel_pkg::pin_drive_t i_src [N],
    output var  pinsel_pkg::pin_drive_t o_pad
);
    import pinsel_pkg::*;

    generate
        if (N < 1)
        begin : g_bad
            $error("pin_route needs at least one source");
        end
    endgenerate

    // Several bits set at once: the upper bit wins so that the pad never sees two drivers
    function automatic pin_drive_t pick(input logic [N-1:0] sel, input pin_drive_t src [N]);
        pin_drive_t r;
        r = '0;
        for (int k = 0; k < N; k++)
        begin
            if (sel[k])
            begin
                r = src[k];
            end
        end
        return r;
    endfunction

    pin_drive_t pad_d;
    assign pad_d = pick(i_sel, i_src);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_pad <= '0;
        else
            o_pad <= pad_d;
    end

endmodule
`default_nettype wire

// ---- logic/line_merge.sv ----
// Registered merge of a shared peripheral input taken from several pins
`timescale 1ns/1ps
`default_nettype none
module line_merge #(
    parameter int N = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    input  wire logic [N-1:0] i_sel,
    input  wire logic [N-1:0] i_pad,
    output logic              o_line
);
    generate
        if (N < 1)
        begin : g_bad
            $error("line_merge needs at least one pin");
        end
    endgenerate

    // Wired-AND: unselected pins read as idle high, as an open-drain bus would
    wire logic merged = &(i_pad | ~i_sel);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_line <= 1'b1;
        else
            o_line <= merged;
    end

endmodule
`default_nettype wire

// ---- logic/port2_pin_function_select.sv ----
// Port-2 pin function select: APB register file and pad routing for pins 1, 3, 4 and 5
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module port2_pin_function_select (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    // APB slave
    input  wire logic                    i_psel,
    input  wire logic                    i_penable,
    input  wire logic                    i_pwrite,
    input  wire logic [pinsel_pkg::ADDR_W-1:0] i_paddr,
    input  wire logic [pinsel_pkg::DATA_W-1:0] i_pwdata,
    input  wire logic [3:0]              i_pstrb,
    output logic                         o_pready,
    output logic                         o_pslverr,
    output logic [pinsel_pkg::DATA_W-1:0] o_prdata,
    // Pads, slot order pin1, pin3, pin4, pin5
    input  wire logic [3:0]              i_pad_in,
    output logic [3:0]                   o_pad_out,
    output logic [3:0]                   o_pad_oe,
    // GPIO controller
    input  wire logic [3:0]              i_gpio_out,
    input  wire logic [3:0]              i_gpio_oe,
    output logic [3:0]                   o_gpio_in,
    // I2C master and slaves: drive low while oe is high
    input  wire logic                    i_i2c_master_unit_sda_oe,
    input  wire logic                    i_i2c_master_unit_scl_oe,
    input  wire logic                    i_i2cs1_sda_oe,
    input  wire logic                    i_i2cs1_scl_oe,
    input  wire logic                    i_i2cs2_sda_oe,
    input  wire logic                    i_i2cs2_scl_oe,
    output logic                         o_i2c_master_unit_sda_in,
    output logic                         o_i2c_master_unit_scl_in,
    output logic                         o_i2cs1_sda_in,
    output logic                         o_i2cs1_scl_in,
    output logic                         o_i2cs2_sda_in,
    output logic                         o_i2cs2_scl_in,
    // Capture/compare channels five and four
    input  wire logic                    i_capcomp5_out,
    input  wire logic                    i_capcomp5_oe,
    input  wire logic                    i_capcomp4_out,
    input  wire logic                    i_capcomp4_oe,
    output logic                         o_capcomp5_in,
    output logic                         o_capcomp4_in,
    // SPI
    input  wire logic                    i_spi_miso_out,
    input  wire logic                    i_spi_miso_oe,
    output logic                         o_spi_miso_in,
    output logic                         o_spi_select_in_n,
    // UARTs
    input  wire logic                    i_uart2_tx,
    input  wire logic                    i_uart3_tx,
    input  wire logic                    i_uart4_tx,
    output logic                         o_uart2_rx,
    output logic                         o_uart3_rx,
    output logic                         o_uart4_rx,
    // PWM, LED segments, timer, analog
    input  wire logic                    i_pwm_unit_one_out,
    input  wire logic                    i_led_seg21,
    input  wire logic                    i_led_seg22,
    input  wire logic                    i_led_seg23,
    output logic                         o_timer2_in,
    output logic                         o_adc_ch1_connect
);
    import pinsel_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode

    apb_req_t req;
    assign req = '{addr: i_paddr, write: i_pwrite, wdata: i_pwdata, strb: i_pstrb};

    wire logic       setup_ph  = i_psel & ~i_penable;
    wire logic       access_ph = i_psel & i_penable;
    wire logic       hit_p1    = (req.addr == reg_addr(PIN1_IDX));
    wire logic       hit_p3    = (req.addr == reg_addr(PIN3_IDX));
    wire logic       hit_p4    = (req.addr == reg_addr(PIN4_IDX));
    wire logic       hit_p5    = (req.addr == reg_addr(PIN5_IDX));
    wire logic       hit_any   = hit_p1 | hit_p3 | hit_p4 | hit_p5;
    logic [1:0]      slot;
    logic [CFG_W-1:0] wmask;

    always_comb
    begin
        if (hit_p1)
        begin
            slot  = 2'(SLOT_P1);
            wmask = PIN1_MASK;
        end
        else if (hit_p3)
        begin
            slot  = 2'(SLOT_P3);
            wmask = PIN3_MASK;
        end
        else if (hit_p4)
        begin
            slot  = 2'(SLOT_P4);
            wmask = PIN4_MASK;
        end
        else
        begin
            slot  = 2'(SLOT_P5);
            wmask = PIN5_MASK;
        end
    end

    // Only byte lane 0 carries a register; other lanes are ignored
    wire logic do_write = access_ph & req.write & hit_any & req.strb[0];

    // Zero wait states; the answer is in the access phase
    assign o_pready  = 1'b1;
    assign o_pslverr = access_ph & ~hit_any;

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    logic [CFG_W-1:0] cfg_q [NPINS];
    logic [CFG_W-1:0] cfg_d;
    assign cfg_d = req.wdata[CFG_W-1:0] & wmask;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < NPINS; k++)
            begin
                cfg_q[k] <= CFG_RESET;
            end
        end
        else if (do_write)
        begin
            cfg_q[slot] <= cfg_d;
        end
    end

    // Read data latched in setup so it stands through the access phase
    logic [DATA_W-1:0] rdata_q;
    wire logic [DATA_W-1:0] rdata_d = hit_any ? DATA_W'(cfg_q[slot]) : '0;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            rdata_q <= '0;
        else if (setup_ph)
            rdata_q <= rdata_d;
    end

    assign o_prdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Select bits

    wire logic [CFG_W-1:0] c1 = cfg_q[SLOT_P1];
    wire logic [CFG_W-1:0] c3 = cfg_q[SLOT_P3];
    wire logic [CFG_W-1:0] c4 = cfg_q[SLOT_P4];
    wire logic [CFG_W-1:0] c5 = cfg_q[SLOT_P5];

    wire logic [3:0] gpio_sel = {c5[GENERAL_IO_SEL], c4[GENERAL_IO_SEL],
                                 c3[GENERAL_IO_SEL], c1[GENERAL_IO_SEL]};

    ////////////////////////////////////////////////////////////////////////////////
    // Pad sources: open-drain users only ever drive low

    pin_drive_t src1 [CFG_W];
    pin_drive_t src3 [CFG_W];
    pin_drive_t src4 [CFG_W];
    pin_drive_t src5 [CFG_W];

    // Analog input and MISO on pin 1
    assign src1[ANALOG_INPUT_ONE_SEL]   = '{out: 1'b0, oe: 1'b0};
    assign src1[SPI_SLAVE_OUT_SEL]      = '{out: i_spi_miso_out, oe: i_spi_miso_oe};
    assign src1[P1_I2C_MASTER_DATA_SEL] = '{out: 1'b0, oe: i_i2c_master_unit_sda_oe};
    assign src1[P1_I2C_SLAVE_ONE_DATA]  = '{out: 1'b0, oe: i_i2cs1_sda_oe};
    assign src1[CAPCOMP_FIVE_IO_SEL]    = '{out: i_capcomp5_out, oe: i_capcomp5_oe};
    assign src1[UART_TWO_TX_SEL]        = '{out: i_uart2_tx, oe: 1'b1};
    assign src1[PWM_UNIT_ONE_OUT_SEL]   = '{out: i_pwm_unit_one_out, oe: 1'b1};
    assign src1[GENERAL_IO_SEL]         = '{out: i_gpio_out[SLOT_P1], oe: i_gpio_oe[SLOT_P1]};

    // Pin 3 functions; receive and select lines leave the pad undriven
    assign src3[LED_SEG_TWENTYTHREE_SEL] = '{out: i_led_seg23, oe: 1'b1};
    assign src3[UART_THREE_TX_SEL]       = '{out: i_uart3_tx, oe: 1'b1};
    assign src3[UART_THREE_RX_SEL]       = '{out: 1'b0, oe: 1'b0};
    assign src3[UART_TWO_RX_SEL]         = '{out: 1'b0, oe: 1'b0};
    assign src3[SPI_SELECT_IN_SEL]       = '{out: 1'b0, oe: 1'b0};
    assign src3[UART_FOUR_TX_SEL]        = '{out: i_uart4_tx, oe: 1'b1};
    assign src3[UART_FOUR_RX_SEL]        = '{out: 1'b0, oe: 1'b0};
    assign src3[GENERAL_IO_SEL]          = '{out: i_gpio_out[SLOT_P3], oe: i_gpio_oe[SLOT_P3]};

    assign src4[LED_SEG_TWENTYTWO_SEL]  = '{out: i_led_seg22, oe: 1'b1};
    assign src4[TIMER_TWO_INPUT_SEL]    = '{out: 1'b0, oe: 1'b0};
    assign src4[P4_I2C_MASTER_DATA_SEL] = '{out: 1'b0, oe: i_i2c_master_unit_sda_oe};
    assign src4[P4_I2C_SLAVE_ONE_DATA]  = '{out: 1'b0, oe: i_i2cs1_sda_oe};
    assign src4[I2C_SLAVE_TWO_DATA_SEL] = '{out: 1'b0, oe: i_i2cs2_sda_oe};
    assign src4[GENERAL_IO_SEL]         = '{out: i_gpio_out[SLOT_P4], oe: i_gpio_oe[SLOT_P4]};
    assign src4[5]                      = '0;
    assign src4[1]                      = '0;

    assign src5[LED_SEG_TWENTYONE_SEL]   = '{out: i_led_seg21, oe: 1'b1};
    assign src5[I2C_SLAVE_TWO_CLOCK_SEL] = '{out: 1'b0, oe: i_i2cs2_scl_oe};
    assign src5[CAPCOMP_FOUR_IO_SEL]     = '{out: i_capcomp4_out, oe: i_capcomp4_oe};
    assign src5[I2C_MASTER_CLOCK_SEL]    = '{out: 1'b0, oe: i_i2c_master_unit_scl_oe};
    assign src5[I2C_SLAVE_ONE_CLOCK_SEL] = '{out: 1'b0, oe: i_i2cs1_scl_oe};
    assign src5[GENERAL_IO_SEL]          = '{out: i_gpio_out[SLOT_P5], oe: i_gpio_oe[SLOT_P5]};
    // Bit 5 is stored and read back but routes nothing here
    assign src5[5]                       = '0;
    assign src5[1]                       = '0;

    pin_drive_t pad [NPINS];

    pin_route #(.N(CFG_W)) u_route_p1 (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_sel (c1),
        .i_src (src1),
        .o_pad (pad[SLOT_P1])
    );

    pin_route #(.N(CFG_W)) u_route_p3 (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_sel (c3),
        .i_src (src3),
        .o_pad (pad[SLOT_P3])
    );

    pin_route #(.N(CFG_W)) u_route_p4 (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_sel (c4),
        .i_src (src4),
        .o_pad (pad[SLOT_P4])
    );

    pin_route #(.N(CFG_W)) u_route_p5 (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .i_sel (c5),
        .i_src (src5),
        .o_pad (pad[SLOT_P5])
    );

    assign o_pad_out = {pad[SLOT_P5].out, pad[SLOT_P4].out, pad[SLOT_P3].out, pad[SLOT_P1].out};
    assign o_pad_oe  = {pad[SLOT_P5].oe, pad[SLOT_P4].oe, pad[SLOT_P3].oe, pad[SLOT_P1].oe};

    ////////////////////////////////////////////////////////////////////////////////
    // Peripheral inputs; unselected lines read idle high

    // Master data from pin 1 or pin 4
    line_merge #(.N(2)) u_in_i2c_master_unit_sda (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_sel  ({c4[P4_I2C_MASTER_DATA_SEL], c1[P1_I2C_MASTER_DATA_SEL]}),
        .i_pad  ({i_pad_in[SLOT_P4], i_pad_in[SLOT_P1]}),
        .o_line (o_i2c_master_unit_sda_in)
    );

    // Slave one data from pin 1 or pin 4
    line_merge #(.N(2)) u_in_i2cs1_sda (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_sel  ({c4[P4_I2C_SLAVE_ONE_DATA], c1[P1_I2C_SLAVE_ONE_DATA]}),
        .i_pad  ({i_pad_in[SLOT_P4], i_pad_in[SLOT_P1]}),
        .o_line (o_i2cs1_sda_in)
    );

    // Single-pin inputs gathered so one generate loop gives each its own merge instance
    localparam int NSINGLE = 12;
    wire logic [NSINGLE-1:0] s_sel = {
        c4[I2C_SLAVE_TWO_DATA_SEL], c5[I2C_MASTER_CLOCK_SEL], c5[I2C_SLAVE_ONE_CLOCK_SEL],
        c5[I2C_SLAVE_TWO_CLOCK_SEL], c1[CAPCOMP_FIVE_IO_SEL], c5[CAPCOMP_FOUR_IO_SEL],
        c1[SPI_SLAVE_OUT_SEL], c3[SPI_SELECT_IN_SEL], c3[UART_TWO_RX_SEL],
        c3[UART_THREE_RX_SEL], c3[UART_FOUR_RX_SEL], c4[TIMER_TWO_INPUT_SEL]};
    wire logic [NSINGLE-1:0] s_pad = {
        i_pad_in[SLOT_P4], i_pad_in[SLOT_P5], i_pad_in[SLOT_P5],
        i_pad_in[SLOT_P5], i_pad_in[SLOT_P1], i_pad_in[SLOT_P5],
        i_pad_in[SLOT_P1], i_pad_in[SLOT_P3], i_pad_in[SLOT_P3],
        i_pad_in[SLOT_P3], i_pad_in[SLOT_P3], i_pad_in[SLOT_P4]};
    logic [NSINGLE-1:0] s_line;

    genvar g;
    generate
        for (g = 0; g < NSINGLE; g++)
        begin : g_single
            line_merge #(.N(1)) u_in (
                .i_clk  (i_clk),
                .i_rst  (i_rst),
                .i_sel  (s_sel[g]),
                .i_pad  (s_pad[g]),
                .o_line (s_line[g])
            );
        end
    endgenerate

    assign o_i2cs2_sda_in    = s_line[11];
    assign o_i2c_master_unit_scl_in     = s_line[10];
    assign o_i2cs1_scl_in    = s_line[9];
    assign o_i2cs2_scl_in    = s_line[8];
    assign o_capcomp5_in     = s_line[7];
    assign o_capcomp4_in     = s_line[6];
    assign o_spi_miso_in     = s_line[5];
    assign o_spi_select_in_n = s_line[4];
    assign o_uart2_rx        = s_line[3];
    assign o_uart3_rx        = s_line[2];
    assign o_uart4_rx        = s_line[1];
    assign o_timer2_in       = s_line[0];

    ////////////////////////////////////////////////////////////////////////////////
    // GPIO input and analog switch, registered

    logic [3:0] gpio_in_q;
    logic       adc_q;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            gpio_in_q <= '0;
            adc_q     <= 1'b0;
        end
        else
        begin
            // GPIO sees the pad only when enabled
            gpio_in_q <= i_pad_in & gpio_sel;
            adc_q     <= c1[ANALOG_INPUT_ONE_SEL];
        end
    end

    assign o_gpio_in         = gpio_in_q;
    assign o_adc_ch1_connect = adc_q;

endmodule
`default_nettype wire

// ---- bench/pinsel_checker.sv ----
// Port-level assertions for the port-2 pin function select block
`timescale 1ns/1ps
`default_nettype none
module pinsel_checker (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [17:0] i_paddr,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic [31:0] o_prdata,
    input wire logic [3:0]  i_pad_in,
    input wire logic [3:0]  o_pad_oe,
    input wire logic [3:0]  o_gpio_in,
    input wire logic        o_i2c_master_unit_sda_in,
    input wire logic        o_uart3_rx,
    input wire logic        o_adc_ch1_connect
);
    import pinsel_pkg::*;
////////////////////////////////////////////////////////////////////////
    logic p1_hit;
    logic mapped;
    assign p1_hit = i_paddr == {PIN1_IDX, 2'b00};
    assign mapped = p1_hit || i_paddr == {PIN3_IDX, 2'b00} || i_paddr == {PIN4_IDX, 2'b00}
                    || i_paddr == {PIN5_IDX, 2'b00};
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_xfer;
        s_setup ##1 (i_psel && i_penable);
    endsequence
////////////////////////////////////////////////////////////////////////
    a_ready_const: assert property (o_pready)
        else $error("pready low");
    a_err_decode: assert property (s_xfer |-> o_pslverr == !mapped)
        else $error("pslverr wrong");
    a_read_width: assert property (s_xfer ##0 !i_pwrite |-> o_prdata[31:8] == 24'h000000)
        else $error("upper read bits set");
    a_adc_copy: assert property (s_xfer ##0 (!i_pwrite && p1_hit) |-> o_prdata[7] == o_adc_ch1_connect)
        else $error("analog select mismatch");
    a_gpio_gate: assert property ((o_gpio_in & ~$past(i_pad_in)) == 4'h0)
        else $error("gpio input not from pad");
    a_sda_line: assert property (!o_i2c_master_unit_sda_in |-> !$past(i_pad_in[0]) || !$past(i_pad_in[2]))
        else $error("master data low without pad");
    a_uart3_line: assert property (!o_uart3_rx |-> !$past(i_pad_in[1]))
        else $error("uart3 rx low without pad");
    a_reset_idle: assert property ($fell(i_rst) |-> (o_pad_oe == 4'h0 && !o_adc_ch1_connect) [*2])
        else $error("pad driven after reset");
endmodule
`default_nettype wire

// ---- bench/port2_pin_function_select_tb.sv ----
// Self-checking testbench of the port-2 pin function select block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; $display("Error %0t: %0h vs %0h", $time, a, e); end end
module port2_pin_function_select_tb;
    import pinsel_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        p     = 1'b1;
    logic        sel   = 1'b0;
    logic        en    = 1'b0;
    apb_req_t    req   = '0;
    logic [3:0]  pad_out, pad_oe, gpio_in, pad_in;
    logic [13:0] ln;
    logic [31:0] prdata;
    logic        pready, pslverr, adc;
    int          fail_count  = 0;
    int          checks_done = 0;
    logic [17:0] addr [4] = '{18'h281C4, 18'h281CC, 18'h281D0, 18'h281D4};
    logic [7:0]  mask [4] = '{8'hFF, 8'hFF, 8'hDD, 8'hFD};
    // Per pin and bit: drive kind times 16 plus line number plus 1; 80 marks reserved
    int          tbl [32] = '{0, 0, 16, 9, 23, 51, 33, 64, 0, 77, 0, 74, 75, 76, 16, 0,
                              0, 80, 51, 33, 78, 80, 37, 16, 0, 80, 36, 50, 8, 64, 54, 0};
    // Pad wire: the design when enabled, else the outside level p
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & {4{p}});
    always #20 i_clk = ~i_clk;
    port2_pin_function_select uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_psel(sel), .i_penable(en), .i_pwrite(req.write),
        .i_paddr(req.addr), .i_pwdata(req.wdata), .i_pstrb(req.strb), .o_pready(pready),
        .o_pslverr(pslverr), .o_prdata(prdata), .i_pad_in(pad_in), .o_pad_out(pad_out),
        .o_pad_oe(pad_oe), .i_gpio_out({4{p}}), .i_gpio_oe(4'hF), .o_gpio_in(gpio_in),
        .i_i2c_master_unit_sda_oe(p), .i_i2c_master_unit_scl_oe(~p), .i_i2cs1_sda_oe(~p), .i_i2cs1_scl_oe(p),
        .i_i2cs2_sda_oe(p), .i_i2cs2_scl_oe(~p), .o_i2c_master_unit_sda_in(ln[0]), .o_i2c_master_unit_scl_in(ln[1]),
        .o_i2cs1_sda_in(ln[2]), .o_i2cs1_scl_in(ln[3]), .o_i2cs2_sda_in(ln[4]), .o_i2cs2_scl_in(ln[5]),
        .i_capcomp5_out(~p), .i_capcomp5_oe(1'b1), .i_capcomp4_out(p), .i_capcomp4_oe(1'b1),
        .o_capcomp5_in(ln[6]), .o_capcomp4_in(ln[7]), .i_spi_miso_out(p), .i_spi_miso_oe(1'b1),
        .o_spi_miso_in(ln[8]), .o_spi_select_in_n(ln[9]), .i_uart2_tx(~p), .i_uart3_tx(~p),
        .i_uart4_tx(p), .o_uart2_rx(ln[10]), .o_uart3_rx(ln[11]), .o_uart4_rx(ln[12]),
        .i_pwm_unit_one_out(p), .i_led_seg21(p), .i_led_seg22(~p), .i_led_seg23(p), .o_timer2_in(ln[13]),
        .o_adc_ch1_connect(adc));
////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [17:0] a, input logic [7:0] d, input logic [3:0] st,
                       output logic [31:0] r, output logic e);
        @(posedge i_clk);
        sel <= 1'b1;
        req <= '{a, w, {24'h000000, d}, st};
        @(posedge i_clk);
        en <= 1'b1;
        @(posedge i_clk);
        while (pready !== 1'b1) @(posedge i_clk);
        r = prdata;
        e = pslverr;
        sel <= 1'b0;
        en <= 1'b0;
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        #1;
        `CHK({pad_oe, gpio_in, ln}, 22'h003FFF)
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b0, addr[s], 8'h00, 4'hF, r, e);
            `CHK(r, 32'h00000000)
            apb(1'b1, addr[s], 8'hFF, 4'hF, r, e);
        end
        // Strobe low must leave the register alone
        apb(1'b1, addr[0], 8'h00, 4'h0, r, e);
        for (int s = 0; s < 4; s++)
        begin
            apb(1'b0, addr[s], 8'h00, 4'hF, r, e);
            `CHK({e, r}, {25'h0, mask[s]})
        end
        apb(1'b0, 18'h281C8, 8'h00, 4'hF, r, e);
        `CHK({e, r}, 33'h100000000)
    endtask
    task automatic t_route;
        logic [31:0] r;
        logic        e, l, eo;
        logic [13:0] el;
        int          c, k;
        // Register test leaves every select set; start from a clean map
        for (int s = 0; s < 4; s++)
            apb(1'b1, addr[s], 8'h00, 4'hF, r, e);
        for (int i = 0; i < 32; i++)
        begin
            c = tbl[i] / 16;
            k = tbl[i] % 16;
            if (c < 5)
            begin
                apb(1'b1, addr[i / 8], 8'(1 << (i % 8)), 4'hF, r, e);
                for (int v = 0; v < 2; v++)
                begin
                    @(posedge i_clk);
                    p <= v[0];
                    repeat (3) @(posedge i_clk);
                    #1;
                    l = (c == 1) ? !p : (c != 2) && p;
                    eo = (c < 2) || (c == 2 && p) || (c == 3 && !p);
                    el = '1;
                    if (k > 0)
                        el[k - 1] = l;
                    `CHK(pad_oe[i / 8], eo)
                    if (c < 4)
                        `CHK(pad_out[i / 8], (c == 0) ? p : (c == 1) && !p)
                    `CHK(ln, el)
                    `CHK(gpio_in, (i % 8 == 0 && l) ? 4'(1 << (i / 8)) : 4'h0)
                    `CHK(adc, i == 7)
                end
                // Drop the select again so the next bit is seen alone
                apb(1'b1, addr[i / 8], 8'h00, 4'hF, r, e);
            end
        end
    endtask
    task automatic finish_test;
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        t_regs();
        t_route();
        finish_test();
    end
    initial
    begin
        repeat (5000) @(posedge i_clk);
        fail_count++;
        finish_test();
    end
endmodule
bind port2_pin_function_select pinsel_checker chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_prdata(o_prdata),
    .i_pad_in(i_pad_in), .o_pad_oe(o_pad_oe), .o_gpio_in(o_gpio_in), .o_i2c_master_unit_sda_in(o_i2c_master_unit_sda_in),
    .o_uart3_rx(o_uart3_rx), .o_adc_ch1_connect(o_adc_ch1_connect));
`default_nettype wire
